// >>> hdl/chfs_top.sv
// Charge fault supervisor: charge rate choice, alarms, charge faults, front-end
// checks and the latched fuse-blow output. Assumes APB master on pclk.
// Notes on behaviour
// - Precharge between inhibit-low and precharge temperature
// - Precharge temperature in tenth-degree steps, signed byte
// - Low cell or empty level latches precharge
// - Fast charge needs threshold plus three degrees
// - Status bits 8-15 alarm the host
// - Status bits 12-15 alarm the charger too
// - Alarms repeat every ten seconds
// - Mute bit suppresses all broadcasts
// - Long overcurrent opens charge, maybe discharge FET
// - Overcurrent clears on removal or non-removable clears
// - Charging overtemperature opens both FETs when enabled
// - Overtemperature clears at reset level or removal
// - Charging undertemperature opens the charge FET
// - Undertemperature clears above suspend-low or removal
// - Charge timer limit opens charge FET
// - Timer pauses below charge-detection current
// - Front-end auto recovery then hold-off
// - Periodic front-end check, scaled while asleep
// - Failed checks counted up to 255, fail limit sets cause
// - Supply the front-end clock continuously
// - Held-low protector input sets its cause
// - Enabled cause drives fuse low, flag set
// - Per-cause enable, all disabled after reset
// - Flag reads zero while fuse output high
// - Front-end cause also needs misc bit 13
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`include "chfs_params.svh"
module chfs_top import chfs_pkg::*; #(
  parameter int unsigned CLK_PER_SEC = `CHFS_CLK_HZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [15:0] temperature,
  input wire logic signed [15:0] measured_current,
  input wire logic signed [15:0] mean_current,
  input wire logic [15:0] min_cell_voltage,
  input wire logic empty_voltage_level_zero,
  input wire logic pack_present,
  input wire logic charging,
  input wire logic asleep,
  input wire logic [15:0] fast_charge_current,
  input wire logic [15:0] pack_status_word,
  input wire logic fe_check_done,
  input wire logic fe_check_ok,
  input wire logic fe_protection_tripped,
  input wire logic secondary_protector_input,
  input wire logic [7:0] external_failure_causes,
  output logic [15:0] requested_charge_current,
  output logic chg_fet_on,
  output logic dsg_fet_on,
  output logic alarm_host_send,
  output logic alarm_charger_send,
  output logic fe_check_request,
  output logic fe_recover,
  output logic fe_retrigger_block,
  output logic front_end_clock_output,
  output logic fuse_blow_n
);
  localparam int NCFG = 23;
  localparam int unsigned FE_HALF = `CHFS_CLK_HZ / (2 * `CHFS_FE_CLK_HZ);
  localparam logic signed [15:0] HYST =
    16'(`CHFS_HYST_DEG_C * `CHFS_TEMP_STEPS_PER_DEG);
  localparam logic [3:0] ALARM_S = 4'(`CHFS_ALARM_PERIOD_S);
  if (CLK_PER_SEC < 2 || FE_HALF < 1) begin : g_bad
    $error("CLK_PER_SEC must be at least 2");
  end

  function automatic chfs_slot_e slot_of(input logic [11:0] idx);
    case (idx)
      `CHFS_IDX_PACK_CFG: slot_of = SL_PACK_CFG;
      `CHFS_IDX_MISC_CFG: slot_of = SL_MISC_CFG;
      `CHFS_IDX_PC_VOLT: slot_of = SL_PC_VOLT;
      `CHFS_IDX_PC_CURR: slot_of = SL_PC_CURR;
      `CHFS_IDX_PC_TEMP: slot_of = SL_PC_TEMP;
      `CHFS_IDX_INH_LOW: slot_of = SL_INH_LOW;
      `CHFS_IDX_CLR_CURR: slot_of = SL_CLR_CURR;
      `CHFS_IDX_SUSP_HI: slot_of = SL_SUSP_HI;
      `CHFS_IDX_SUSP_HI_RST: slot_of = SL_SUSP_HI_RST;
      `CHFS_IDX_SUSP_LO: slot_of = SL_SUSP_LO;
      `CHFS_IDX_FE_FAIL_LIM: slot_of = SL_FE_FAIL_LIM;
      `CHFS_IDX_FE_CHECK: slot_of = SL_FE_CHECK;
      `CHFS_IDX_SLEEP_MULT: slot_of = SL_SLEEP_MULT;
      `CHFS_IDX_MAX_CHG: slot_of = SL_MAX_CHG;
      `CHFS_IDX_PF_ENABLE: slot_of = SL_PF_ENABLE;
      `CHFS_IDX_OC_THR: slot_of = SL_OC_THR;
      `CHFS_IDX_OC_TIME: slot_of = SL_OC_TIME;
      `CHFS_IDX_CLR_TIME: slot_of = SL_CLR_TIME;
      `CHFS_IDX_FE_REC: slot_of = SL_FE_REC;
      `CHFS_IDX_FE_HOLD: slot_of = SL_FE_HOLD;
      `CHFS_IDX_MISC2: slot_of = SL_MISC2;
      `CHFS_IDX_CHG_DET: slot_of = SL_CHG_DET;
      `CHFS_IDX_SECONDARY_PROTECTOR_INPUT_TIME: slot_of = SL_SECONDARY_PROTECTOR_INPUT_TIME;
      `CHFS_IDX_FAILURE_LATCH_FLAG: slot_of = SL_FAILURE_LATCH_FLAG;
      `CHFS_IDX_STATUS: slot_of = SL_STATUS;
      `CHFS_IDX_FAILURE_CAUSE_STATUS: slot_of = SL_FAILURE_CAUSE_STATUS;
      default: slot_of = SL_NONE;
    endcase
  endfunction

  // Byte-wide settings keep only their low eight bits
  function automatic chfs_word_t width_mask(input chfs_slot_e s);
    case (s)
      SL_PACK_CFG, SL_MISC_CFG, SL_PC_VOLT, SL_PC_CURR, SL_CLR_CURR, SL_SUSP_HI,
      SL_SUSP_HI_RST, SL_MAX_CHG, SL_OC_THR, SL_CHG_DET: width_mask = 16'hFFFF;
      default: width_mask = 16'h00FF;
    endcase
  endfunction

  function automatic logic signed [15:0] temp8(input chfs_word_t v);
    temp8 = 16'(signed'(v[7:0]));
  endfunction

  chfs_word_t cfg_r [NCFG];
  chfs_word_t cfg_nxt [NCFG];
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [31:0] sec_cnt_r, sec_cnt_nxt;
  logic tick_r, tick_nxt;
  logic [8:0] fe_div_r, fe_div_nxt;
  logic fe_clk_r, fe_clk_nxt;
  logic pc_volt_r, pc_volt_nxt, pc_temp_r, pc_temp_nxt;
  logic [15:0] req_cur_r, req_cur_nxt;
  logic [3:0] al_tmr_r, al_tmr_nxt;
  logic al_host_r, al_host_nxt, al_chg_r, al_chg_nxt;
  logic [8:0] oc_cnt_r, oc_cnt_nxt, clr_cnt_r, clr_cnt_nxt;
  logic oc_f_r, oc_f_nxt, ot_f_r, ot_f_nxt, ut_f_r, ut_f_nxt, mt_f_r, mt_f_nxt;
  logic [15:0] chg_time_r, chg_time_nxt;
  logic chg_fet_r, chg_fet_nxt, dsg_fet_r, dsg_fet_nxt;
  chfs_check_e chk_st_r, chk_st_nxt;
  logic [15:0] chk_cnt_r, chk_cnt_nxt;
  logic [7:0] fail_cnt_r, fail_cnt_nxt;
  logic [8:0] rec_cnt_r, rec_cnt_nxt, hold_cnt_r, hold_cnt_nxt;
  logic fe_rec_r, fe_rec_nxt, fe_blk_r, fe_blk_nxt;
  logic [8:0] secondary_protector_input_cnt_r, secondary_protector_input_cnt_nxt;
  logic [7:0] failure_cause_status_r, failure_cause_status_nxt, failure_latch_flag_r, failure_latch_flag_nxt;
  logic safe_n_r, safe_n_nxt;

  chfs_slot_e slot;
  logic acc_done, mute, nonrem, removed, clr_evt, pf_trig, oc_over;
  logic signed [15:0] pc_thr, inh_low, susp_lo;
  logic [15:0] chk_period;
  logic [7:0] pf_armed;

  always_comb begin
    slot = slot_of(paddr[13:2]);
    acc_done = psel && penable && pready_r;
    mute = cfg_r[SL_PACK_CFG][`CHFS_BIT_MUTE];
    nonrem = cfg_r[SL_MISC_CFG][`CHFS_BIT_NONREMOVABLE];
    removed = !pack_present;
    pc_thr = temp8(cfg_r[SL_PC_TEMP]);
    inh_low = temp8(cfg_r[SL_INH_LOW]);
    susp_lo = temp8(cfg_r[SL_SUSP_LO]);
    oc_over = measured_current > signed'(cfg_r[SL_OC_THR]);
    clr_evt = removed || (nonrem && (measured_current < 16'sh0000 ||
      clr_cnt_r >= {1'b0, cfg_r[SL_CLR_TIME][7:0]}));
    chk_period = asleep ? 16'(cfg_r[SL_FE_CHECK][7:0]) * 16'(cfg_r[SL_SLEEP_MULT][7:0])
                        : cfg_r[SL_FE_CHECK];
    pf_armed = failure_cause_status_r & cfg_r[SL_PF_ENABLE][7:0];
    pf_armed[`CHFS_PF_FE_BIT] = pf_armed[`CHFS_PF_FE_BIT] &&
      cfg_r[SL_MISC_CFG][`CHFS_BIT_FE_PF_ALLOW];
    pf_trig = |pf_armed;
  end

  // Register file and APB, one wait state before pready
  always_comb begin
    cfg_nxt = cfg_r;
    pready_nxt = psel && penable && !pready_r;
    pslverr_nxt = pready_nxt && slot == SL_NONE;
    prdata_nxt = prdata_r;
    if (pready_nxt && !pwrite) begin
      case (slot)
        SL_FAILURE_LATCH_FLAG: prdata_nxt = {24'h000000, failure_latch_flag_r};
        SL_STATUS: prdata_nxt = {16'h0000, fail_cnt_r, chk_st_r == CHK_WAIT, pc_volt_r,
          dsg_fet_r, chg_fet_r, mt_f_r, ut_f_r, ot_f_r, oc_f_r};
        SL_FAILURE_CAUSE_STATUS: prdata_nxt = {24'h000000, failure_cause_status_r};
        SL_NONE: prdata_nxt = 32'h00000000;
        default: prdata_nxt = {16'h0000, cfg_r[slot]};
      endcase
    end
    if (acc_done && pwrite && slot < SL_FAILURE_LATCH_FLAG) begin
      cfg_nxt[slot] = pwdata[15:0] & width_mask(slot);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCFG; i++) begin
        cfg_r[i] <= `CHFS_CFG_RESET;
      end
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Time base, charge control, faults, front end and failure latch
  always_comb begin
    tick_nxt = sec_cnt_r == 32'(CLK_PER_SEC - 1);
    sec_cnt_nxt = tick_nxt ? 32'h00000000 : sec_cnt_r + 32'h00000001;
    fe_div_nxt = fe_div_r + 9'h001;
    fe_clk_nxt = fe_clk_r;
    if (fe_div_r == 9'(FE_HALF - 1)) begin
      fe_div_nxt = 9'h000;
      fe_clk_nxt = !fe_clk_r;
    end
    pc_volt_nxt = pc_volt_r;
    if (min_cell_voltage < cfg_r[SL_PC_VOLT] || empty_voltage_level_zero) begin
      pc_volt_nxt = 1'b1;
    end else if (min_cell_voltage > cfg_r[SL_PC_VOLT]) begin
      pc_volt_nxt = 1'b0;
    end
    pc_temp_nxt = pc_temp_r;
    if (temperature >= inh_low && temperature < pc_thr) begin
      pc_temp_nxt = 1'b1;
    end else if (temperature >= pc_thr + HYST || temperature < inh_low) begin
      pc_temp_nxt = 1'b0;
    end
    req_cur_nxt = (pc_volt_nxt || pc_temp_nxt) ? cfg_r[SL_PC_CURR] : fast_charge_current;
    al_host_nxt = 1'b0;
    al_chg_nxt = 1'b0;
    al_tmr_nxt = (tick_r && al_tmr_r != 4'h0) ? al_tmr_r - 4'h1 : al_tmr_r;
    if (pack_status_word[15:8] == 8'h00) begin
      al_tmr_nxt = 4'h0;
    end else if (al_tmr_r == 4'h0) begin
      al_tmr_nxt = ALARM_S;
      al_host_nxt = !mute;
      al_chg_nxt = !mute && pack_status_word[15:12] != 4'h0;
    end
    oc_cnt_nxt = !oc_over ? 9'h000 :
                 (tick_r && oc_cnt_r != 9'h1FF) ? oc_cnt_r + 9'h001 : oc_cnt_r;
    clr_cnt_nxt = (mean_current >= signed'(cfg_r[SL_CLR_CURR]) || !oc_f_r) ? 9'h000 :
                  (tick_r && clr_cnt_r != 9'h1FF) ? clr_cnt_r + 9'h001 : clr_cnt_r;
    oc_f_nxt = oc_f_r && !clr_evt;
    if (oc_cnt_r > {1'b0, cfg_r[SL_OC_TIME][7:0]}) begin
      oc_f_nxt = 1'b1;
    end
    ot_f_nxt = ot_f_r && !(removed || temperature <= signed'(cfg_r[SL_SUSP_HI_RST]));
    if (charging && temperature > signed'(cfg_r[SL_SUSP_HI]) &&
        cfg_r[SL_MISC_CFG][`CHFS_BIT_OT_ACTION]) begin
      ot_f_nxt = 1'b1;
    end
    ut_f_nxt = ut_f_r && !(removed || temperature > susp_lo);
    if (charging && (temperature < susp_lo || temperature < inh_low)) begin
      ut_f_nxt = 1'b1;
    end
    chg_time_nxt = chg_time_r;
    if (charging && tick_r && chg_time_r != 16'hFFFF &&
        !(cfg_r[SL_MISC2][`CHFS_BIT_TIMER_PAUSE] &&
          measured_current < signed'(cfg_r[SL_CHG_DET]))) begin
      chg_time_nxt = chg_time_r + 16'h0001;
    end
    mt_f_nxt = mt_f_r;
    if (removed || measured_current < 16'sh0000) begin
      mt_f_nxt = 1'b0;
      chg_time_nxt = 16'h0000;
    end
    if (cfg_r[SL_MAX_CHG] != 16'h0000 && chg_time_r >= cfg_r[SL_MAX_CHG]) begin
      mt_f_nxt = 1'b1;
    end
    chg_fet_nxt = !(oc_f_nxt || ot_f_nxt || ut_f_nxt || mt_f_nxt);
    dsg_fet_nxt = !((oc_f_nxt && !nonrem) || ot_f_nxt);
    chk_st_nxt = chk_st_r;
    chk_cnt_nxt = chk_cnt_r;
    fail_cnt_nxt = fail_cnt_r;
    failure_cause_status_nxt = failure_cause_status_r | external_failure_causes;
    case (chk_st_r)
      CHK_IDLE: begin
        if (cfg_r[SL_FE_CHECK][7:0] == 8'h00) begin
          chk_cnt_nxt = 16'h0000;
        end else if (tick_r) begin
          chk_cnt_nxt = chk_cnt_r + 16'h0001;
          if (chk_cnt_r + 16'h0001 >= chk_period) begin
            chk_cnt_nxt = 16'h0000;
            chk_st_nxt = CHK_WAIT;
          end
        end
      end
      CHK_WAIT: begin
        if (fe_check_done) begin
          chk_st_nxt = CHK_IDLE;
          if (!fe_check_ok && fail_cnt_r != 8'hFF) begin
            fail_cnt_nxt = fail_cnt_r + 8'h01;
          end
          if (!fe_check_ok && fail_cnt_r + 8'h01 >= cfg_r[SL_FE_FAIL_LIM][7:0]) begin
            failure_cause_status_nxt[`CHFS_PF_FE_BIT] = 1'b1;
          end
        end
      end
      default: chk_st_nxt = CHK_IDLE;
    endcase
    fe_rec_nxt = 1'b0;
    rec_cnt_nxt = rec_cnt_r;
    hold_cnt_nxt = (tick_r && hold_cnt_r != 9'h000) ? hold_cnt_r - 9'h001 : hold_cnt_r;
    if (!fe_protection_tripped || cfg_r[SL_FE_REC][7:0] == 8'h00) begin
      rec_cnt_nxt = 9'h000;
    end else if (rec_cnt_r >= {1'b0, cfg_r[SL_FE_REC][7:0]}) begin
      fe_rec_nxt = 1'b1;
      rec_cnt_nxt = 9'h000;
      hold_cnt_nxt = {1'b0, cfg_r[SL_FE_HOLD][7:0]};
    end else if (tick_r) begin
      rec_cnt_nxt = rec_cnt_r + 9'h001;
    end
    fe_blk_nxt = hold_cnt_nxt != 9'h000;
    secondary_protector_input_cnt_nxt = secondary_protector_input ? 9'h000 :
                   (tick_r && secondary_protector_input_cnt_r != 9'h1FF) ? secondary_protector_input_cnt_r + 9'h001 : secondary_protector_input_cnt_r;
    if (!secondary_protector_input &&
        secondary_protector_input_cnt_r >= {1'b0, cfg_r[SL_SECONDARY_PROTECTOR_INPUT_TIME][7:0]}) begin
      failure_cause_status_nxt[`CHFS_PF_PROT_BIT] = 1'b1;
    end
    safe_n_nxt = safe_n_r && !pf_trig;
    failure_latch_flag_nxt = safe_n_nxt ? `CHFS_FAILURE_LATCH_FLAG_CLEAR : `CHFS_FAILURE_LATCH_FLAG_SET;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_cnt_r <= 32'h00000000;
      tick_r <= 1'b0;
      fe_div_r <= 9'h000;
      fe_clk_r <= 1'b0;
      pc_volt_r <= 1'b0;
      pc_temp_r <= 1'b0;
      req_cur_r <= 16'h0000;
      al_tmr_r <= 4'h0;
      al_host_r <= 1'b0;
      al_chg_r <= 1'b0;
      oc_cnt_r <= 9'h000;
      clr_cnt_r <= 9'h000;
      oc_f_r <= 1'b0;
      ot_f_r <= 1'b0;
      ut_f_r <= 1'b0;
      mt_f_r <= 1'b0;
      chg_time_r <= 16'h0000;
      chg_fet_r <= 1'b0;
      dsg_fet_r <= 1'b0;
      chk_st_r <= CHK_IDLE;
      chk_cnt_r <= 16'h0000;
      fail_cnt_r <= 8'h00;
      rec_cnt_r <= 9'h000;
      hold_cnt_r <= 9'h000;
      fe_rec_r <= 1'b0;
      fe_blk_r <= 1'b0;
      secondary_protector_input_cnt_r <= 9'h000;
      failure_cause_status_r <= 8'h00;
      failure_latch_flag_r <= `CHFS_FAILURE_LATCH_FLAG_CLEAR;
      safe_n_r <= 1'b1;
    end else begin
      sec_cnt_r <= sec_cnt_nxt;
      tick_r <= tick_nxt;
      fe_div_r <= fe_div_nxt;
      fe_clk_r <= fe_clk_nxt;
      pc_volt_r <= pc_volt_nxt;
      pc_temp_r <= pc_temp_nxt;
      req_cur_r <= req_cur_nxt;
      al_tmr_r <= al_tmr_nxt;
      al_host_r <= al_host_nxt;
      al_chg_r <= al_chg_nxt;
      oc_cnt_r <= oc_cnt_nxt;
      clr_cnt_r <= clr_cnt_nxt;
      oc_f_r <= oc_f_nxt;
      ot_f_r <= ot_f_nxt;
      ut_f_r <= ut_f_nxt;
      mt_f_r <= mt_f_nxt;
      chg_time_r <= chg_time_nxt;
      chg_fet_r <= chg_fet_nxt;
      dsg_fet_r <= dsg_fet_nxt;
      chk_st_r <= chk_st_nxt;
      chk_cnt_r <= chk_cnt_nxt;
      fail_cnt_r <= fail_cnt_nxt;
      rec_cnt_r <= rec_cnt_nxt;
      hold_cnt_r <= hold_cnt_nxt;
      fe_rec_r <= fe_rec_nxt;
      fe_blk_r <= fe_blk_nxt;
      secondary_protector_input_cnt_r <= secondary_protector_input_cnt_nxt;
      failure_cause_status_r <= failure_cause_status_nxt;
      failure_latch_flag_r <= failure_latch_flag_nxt;
      safe_n_r <= safe_n_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign requested_charge_current = req_cur_r;
  assign chg_fet_on = chg_fet_r;
  assign dsg_fet_on = dsg_fet_r;
  assign alarm_host_send = al_host_r;
  assign alarm_charger_send = al_chg_r;
  assign fe_check_request = chk_st_r == CHK_WAIT;
  assign fe_recover = fe_rec_r;
  assign fe_retrigger_block = fe_blk_r;
  assign front_end_clock_output = fe_clk_r;
  assign fuse_blow_n = safe_n_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_PC_TEMP: assert property (temperature >= inh_low && temperature < pc_thr |=>
    requested_charge_current == $past(cfg_r[SL_PC_CURR])) else $error("no precharge");
  AST_PC_VOLT: assert property (min_cell_voltage < cfg_r[SL_PC_VOLT] |=> pc_volt_r [*1]
    ##0 requested_charge_current == $past(cfg_r[SL_PC_CURR])) else $error("volt precharge");
  AST_HYST: assert property ($fell(pc_temp_r) |-> $past(temperature) >= $past(pc_thr) + HYST
    || $past(temperature) < $past(inh_low)) else $error("early fast charge");
  AST_MUTE: assert property (mute && $past(mute) |-> !alarm_host_send && !alarm_charger_send)
    else $error("broadcast while muted");
  AST_CHG_ALARM: assert property (alarm_charger_send |-> alarm_host_send &&
    $past(pack_status_word[15:12]) != 4'h0) else $error("charger alarm cause");
  AST_OC: assert property (oc_f_r |-> !chg_fet_on && (dsg_fet_on == 1'b0 || $past(nonrem)))
    else $error("overcurrent FET state");
  AST_OT: assert property (ot_f_r |-> !chg_fet_on && !dsg_fet_on)
    else $error("overtemp FET state");
  AST_FUSE: assert property (pf_trig |=> !fuse_blow_n && failure_latch_flag_r == `CHFS_FAILURE_LATCH_FLAG_SET)
    else $error("fuse not blown");
  AST_LATCH: assert property (!fuse_blow_n |=> !fuse_blow_n [*2])
    else $error("fuse released");
  AST_FLAG_CLR: assert property (fuse_blow_n |-> failure_latch_flag_r == `CHFS_FAILURE_LATCH_FLAG_CLEAR)
    else $error("flag set while fuse high");
  COV_ALARM: cover property (alarm_host_send && alarm_charger_send);
  COV_OC: cover property ($rose(oc_f_r) ##[1:20] $fell(oc_f_r));
  COV_FUSE: cover property ($fell(fuse_blow_n));
  COV_CHECK: cover property (fe_check_request ##1 fe_check_done && !fe_check_ok);
endmodule

// >>> hdl/chfs_params.svh
// Offsets, field positions, reset values and timing figures of the charge supervisor.
// Assumes inclusion by bare name from the top module and the bench.
`ifndef CHFS_PARAMS_SVH
`define CHFS_PARAMS_SVH
// Register indexes, byte address is four times the index
`define CHFS_IDX_PACK_CFG 12'h028
`define CHFS_IDX_MISC_CFG 12'h02A
`define CHFS_IDX_PC_VOLT 12'h03C
`define CHFS_IDX_PC_CURR 12'h042
`define CHFS_IDX_PC_TEMP 12'h044
`define CHFS_IDX_INH_LOW 12'h046
`define CHFS_IDX_CLR_CURR 12'h061
`define CHFS_IDX_SUSP_HI 12'h06D
`define CHFS_IDX_SUSP_HI_RST 12'h06F
`define CHFS_IDX_SUSP_LO 12'h079
`define CHFS_IDX_FE_FAIL_LIM 12'h0E4
`define CHFS_IDX_FE_CHECK 12'h0FB
`define CHFS_IDX_SLEEP_MULT 12'h0FD
`define CHFS_IDX_MAX_CHG 12'h10F
`define CHFS_IDX_FAILURE_LATCH_FLAG 12'h11E
`define CHFS_IDX_PF_ENABLE 12'h11F
`define CHFS_IDX_OC_THR 12'h12A
`define CHFS_IDX_OC_TIME 12'h12C
`define CHFS_IDX_CLR_TIME 12'h130
`define CHFS_IDX_FE_REC 12'h160
`define CHFS_IDX_FE_HOLD 12'h161
`define CHFS_IDX_MISC2 12'h200
`define CHFS_IDX_CHG_DET 12'h201
`define CHFS_IDX_SECONDARY_PROTECTOR_INPUT_TIME 12'h202
`define CHFS_IDX_STATUS 12'h203
`define CHFS_IDX_FAILURE_CAUSE_STATUS 12'h204
// Field positions
`define CHFS_BIT_MUTE 2
`define CHFS_BIT_NONREMOVABLE 8
`define CHFS_BIT_OT_ACTION 9
`define CHFS_BIT_FE_PF_ALLOW 13
`define CHFS_BIT_TIMER_PAUSE 7
`define CHFS_PF_FE_BIT 3
`define CHFS_PF_PROT_BIT 6
// Reset and latch values
`define CHFS_CFG_RESET 16'h0000
`define CHFS_FAILURE_LATCH_FLAG_CLEAR 8'h00
`define CHFS_FAILURE_LATCH_FLAG_SET 8'h66
// Timing
`define CHFS_CLK_HZ 20000000
`define CHFS_FE_CLK_HZ 32768
`define CHFS_ALARM_PERIOD_S 10
`define CHFS_HYST_DEG_C 3
`define CHFS_TEMP_STEPS_PER_DEG 10
`endif

// >>> hdl/chfs_pkg.sv
// Types shared by the charge supervisor.
// Assumes chfs_params.svh on the include path.
package chfs_pkg;
  typedef enum logic [4:0] {
    SL_PACK_CFG, SL_MISC_CFG, SL_PC_VOLT, SL_PC_CURR, SL_PC_TEMP, SL_INH_LOW,
    SL_CLR_CURR, SL_SUSP_HI, SL_SUSP_HI_RST, SL_SUSP_LO, SL_FE_FAIL_LIM,
    SL_FE_CHECK, SL_SLEEP_MULT, SL_MAX_CHG, SL_PF_ENABLE, SL_OC_THR, SL_OC_TIME,
    SL_CLR_TIME, SL_FE_REC, SL_FE_HOLD, SL_MISC2, SL_CHG_DET, SL_SECONDARY_PROTECTOR_INPUT_TIME,
    SL_FAILURE_LATCH_FLAG, SL_STATUS, SL_FAILURE_CAUSE_STATUS, SL_NONE
  } chfs_slot_e;
  typedef enum logic {CHK_IDLE, CHK_WAIT} chfs_check_e;
  typedef logic [15:0] chfs_word_t;
endpackage

// >>> testbench/chfs_fe_model.sv
// Front-end protection chip model: answers integrity checks and watches its clock.
// Assumes check requests from the supervisor on pclk.
`timescale 1ns/1ps
module chfs_fe_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fe_check_request,
  input wire logic fail_mode,
  input wire logic front_end_clock_output,
  output logic fe_check_done,
  output logic fe_check_ok,
  output logic fe_protection_tripped
);
  logic [1:0] dly;
  logic [9:0] idle;
  logic last_clk;
  // Clock loss trips, clock return clears
  assign fe_protection_tripped = (idle > 10'd700);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly <= 0;
      fe_check_done <= 0;
      fe_check_ok <= 0;
      idle <= 0;
      last_clk <= 0;
    end else begin
      last_clk <= front_end_clock_output;
      idle <= (last_clk != front_end_clock_output) ? 10'd0 : idle + (idle != 10'h3FF);
      fe_check_done <= 0;
      fe_check_ok <= fail_mode;
      // Answer a few cycles after the request
      if (fe_check_request && !fe_check_done) begin
        dly <= dly + 1;
        if (dly == 2'd3) begin
          fe_check_done <= 1;
          fe_check_ok <= !fail_mode;
        end
      end
    end
  end
endmodule

// >>> testbench/tb.sv
// Bench for the charge supervisor: APB register tasks and directed checks.
// Assumes one second equals 20 pclk cycles.
`timescale 1ns/1ps
`include "chfs_params.svh"
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [13:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic pready, pslverr, e, fail_mode = 0;
  logic signed [15:0] temperature = 20, measured_current = 0, mean_current = 0;
  logic [15:0] min_cell_voltage = 3000, fast_charge_current = 16'h0456;
  logic [15:0] pack_status_word = 0, requested_charge_current;
  logic empty_voltage_level_zero = 0, pack_present = 1, charging = 0, asleep = 0;
  logic secondary_protector_input = 1;
  logic [7:0] external_failure_causes = 0;
  logic fe_check_done, fe_check_ok, fe_protection_tripped, chg_fet_on, dsg_fet_on;
  logic alarm_host_send, alarm_charger_send, fe_check_request, fe_recover;
  logic fe_retrigger_block, front_end_clock_output, fuse_blow_n;
  int err_count = 0, comparisons = 0, cyc = 0, nh = 0, nc = 0, h0, c0;
  chfs_top #(.CLK_PER_SEC(20)) chfs_top_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .temperature, .measured_current,
    .mean_current, .min_cell_voltage, .empty_voltage_level_zero, .pack_present, .charging,
    .asleep, .fast_charge_current, .pack_status_word, .fe_check_done, .fe_check_ok,
    .fe_protection_tripped, .secondary_protector_input, .external_failure_causes,
    .requested_charge_current, .chg_fet_on, .dsg_fet_on, .alarm_host_send,
    .alarm_charger_send, .fe_check_request, .fe_recover, .fe_retrigger_block,
    .front_end_clock_output, .fuse_blow_n);
  chfs_fe_model chfs_fe_model_inst (.pclk, .presetn, .fe_check_request, .fail_mode,
    .front_end_clock_output, .fe_check_done, .fe_check_ok, .fe_protection_tripped);
  initial begin
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    nh <= nh + (alarm_host_send === 1'b1);
    nc <= nc + (alarm_charger_send === 1'b1);
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end
  task summarize();
    if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x) begin
      err_count++;
      $display("ERROR %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task apb(input logic w, input logic [11:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input logic [11:0] idx, input logic [31:0] d);
    apb(1, idx, d);
  endtask
  task rd(input logic [11:0] idx, input logic [31:0] x);
    apb(0, idx, 0);
    chk(q, x);
  endtask
  task wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  initial begin
    wt(2);
    presetn <= 1;
    chk(fuse_blow_n, 1);
    rd(`CHFS_IDX_FAILURE_LATCH_FLAG, 0);
    rd(`CHFS_IDX_PF_ENABLE, 0);
    rd(12'h3FF, 0);
    chk(e, 1);
    wr(`CHFS_IDX_PC_TEMP, 50);
    wr(`CHFS_IDX_PC_CURR, 16'h0123);
    wt(3);
    chk(requested_charge_current, 16'h0123);
    temperature <= 79;
    wt(3);
    chk(requested_charge_current, 16'h0123);
    temperature <= 80;
    wt(3);
    chk(requested_charge_current, 16'h0456);
    wr(`CHFS_IDX_PC_VOLT, 3500);
    wt(3);
    chk(requested_charge_current, 16'h0123);
    min_cell_voltage <= 3600;
    wt(3);
    chk(requested_charge_current, 16'h0456);
    h0 = nh;
    c0 = nc;
    pack_status_word <= 16'h1000;
    wt(300);
    chk(nh - h0, 2);
    chk(nc - c0, 2);
    pack_status_word <= 16'h0100;
    wt(350);
    chk(nh - h0, 4);
    chk(nc - c0, 2);
    wr(`CHFS_IDX_PACK_CFG, 4);
    wt(300);
    chk(nh - h0, 4);
    pack_status_word <= 0;
    wr(`CHFS_IDX_OC_THR, 100);
    wr(`CHFS_IDX_OC_TIME, 1);
    charging <= 1;
    measured_current <= 200;
    wt(15);
    chk(chg_fet_on, 1);
    wt(55);
    chk({chg_fet_on, dsg_fet_on}, 0);
    measured_current <= 0;
    wt(40);
    chk(chg_fet_on, 0);
    pack_present <= 0;
    wt(3);
    pack_present <= 1;
    wt(3);
    chk({chg_fet_on, dsg_fet_on}, 2'b11);
    wr(`CHFS_IDX_MISC_CFG, 16'h0200);
    wt(3);
    chk({chg_fet_on, dsg_fet_on}, 0);
    wr(`CHFS_IDX_MISC_CFG, 0);
    temperature <= 0;
    wt(3);
    chk({chg_fet_on, dsg_fet_on}, 2'b11);
    temperature <= -10;
    wt(3);
    chk({chg_fet_on, dsg_fet_on}, 2'b01);
    temperature <= 80;
    wt(3);
    chk({chg_fet_on, dsg_fet_on}, 2'b11);
    wr(`CHFS_IDX_MAX_CHG, 2);
    wt(60);
    chk(chg_fet_on, 0);
    measured_current <= -5;
    wt(3);
    chk(chg_fet_on, 1);
    wr(`CHFS_IDX_MAX_CHG, 0);
    measured_current <= 0;
    fail_mode <= 1;
    wr(`CHFS_IDX_FE_FAIL_LIM, 2);
    wr(`CHFS_IDX_FE_CHECK, 1);
    wr(`CHFS_IDX_PF_ENABLE, 8);
    wt(120);
    rd(`CHFS_IDX_FAILURE_CAUSE_STATUS, 8);
    chk(fuse_blow_n, 1);
    wr(`CHFS_IDX_MISC_CFG, 16'h2000);
    wt(4);
    chk(fuse_blow_n, 0);
    rd(`CHFS_IDX_FAILURE_LATCH_FLAG, 8'h66);
    wr(`CHFS_IDX_PF_ENABLE, 0);
    wt(40);
    chk(fuse_blow_n, 0);
    rd(`CHFS_IDX_FAILURE_LATCH_FLAG, 8'h66);
    secondary_protector_input <= 0;
    wt(3);
    rd(`CHFS_IDX_FAILURE_CAUSE_STATUS, 8'h48);
    summarize();
  end
endmodule
